// file: hdl/scr_config_regs.sv
// Configuration register bank, offsets 0x00 to 0x04, of the serializer.
// Assumes accesses arrive already decoded from the control channel and
// that every input is synchronous to clk_sys_in.
//
// Functional notes
// - Register accesses are accepted only while the control channel is in base mode.
// - Offset 0x00 holds own address, offset 0x01 the paired deserializer address.
// - Own address powers up as 0x80, upper seven bits 1000000.
// - With the lock bit clear, offsets 0x00 to 0x04 are writable; 0x05 to 0x1F read as zero and drop writes.
// - Partner address powers up as 1001000 with reserved low bit, 0x90.
// - Spread field bits 7:5 default 00X, low bit from straps 1:0.
// - Pixel clock range defaults to 11, automatic detection.
// - Serial rate range defaults to 11, automatic detection.
// - Modulation rate calibration defaults to 00, calibrate once after lock.
// - Sawtooth divider defaults to 000000, automatic calibration.
// - Serial link enable default follows strap 2 at power-up.
// - Configuration link enable resets to 0.
// - Pattern test enable resets to 0.
// - Sleep default follows the direction pin and straps 3:2.
// - Interface type defaults 01; UART when select 0, direction 1, role 0.
// - Reverse channel enable, bit 1 of offset 0x04, resets to 1.
// - Forward channel enable, bit 0 of offset 0x04, resets to 1.
// - Bypass mode carries a user UART protocol, not device register framing.
// - UART control protocol is full duplex, I2C only half duplex.
// - Straps are sampled at power-up and on every exit from power-down.
`timescale 1ns/1ps
`default_nettype none

module scr_config_regs #(
	parameter int unsigned STRAP_PINS = 4	// Three-level strap pins.
) (
	input  wire logic                 clk_sys_in,              // 200 MHz.
	input  wire logic                 rst_n_in,                // Async reset.
	input  wire logic                 power_down_n_in,         // Low: down.
	input  wire logic [7:0]           strap_inputs_in,         // 2 bits/pin.
	input  wire logic                 control_direction_pin_in,// Direction.
	input  wire logic                 role_select_pin_in,      // Role pin.
	input  wire logic                 control_interface_select_in, // 0: UART.
	input  wire logic                 base_mode_in,            // 1: base.
	input  wire scr_pkg::scr_access_t access_in,               // Access.
	output var  logic                 ready_out,               // Bank loaded.
	output var  logic                 done_out,                // Taken pulse.
	output var  logic [7:0]           rd_data_out,             // Read data.
	output var  scr_pkg::scr_config_t config_out,              // Fields.
	output var  logic                 full_duplex_out          // UART duplex.
);

	// The strap vector is fixed at two bits for each of four pins.
	initial
	begin
		if (STRAP_PINS != 4)
			$error("scr_config_regs serves exactly four strap pins.");
	end

	// A strap counts as set unless it is tied low; open counts as set.
	function automatic logic strap_set(input logic [1:0] level);
		return level != scr_pkg::LVL_LOW;
	endfunction

	scr_pkg::scr_state_t state;
	logic [7:0]          bank [0:scr_pkg::REG_COUNT-1];
	logic                take;
	logic                locked;
	logic                in_window;
	logic                strap_spread;
	logic                strap_link;
	logic                strap_sleep;
	logic [7:0]          next_rd_data;

	// Strap decode. Straps 1:0 pick the spread bit, strap 2 the link.
	// Sleep is taken only when the direction pin is high and the link
	// strap leaves the serial link off, so a remote controller wakes it.
	assign strap_spread = strap_set(strap_inputs_in[1:0])
		| strap_set(strap_inputs_in[3:2]);
	assign strap_link   = strap_set(strap_inputs_in[5:4]);
	assign strap_sleep  = control_direction_pin_in
		& ~strap_set(strap_inputs_in[7:6]) & ~strap_link;

	// Only base-mode traffic on a loaded bank reaches the registers; in
	// bypass the channel carries user frames that must never decode here.
	assign take      = access_in.valid && state == scr_pkg::SCR_ST_RUN
		&& base_mode_in;
	assign locked    = bank[0][scr_pkg::BIT_LOCK];
	assign in_window = access_in.addr <= scr_pkg::ADDR_LOCK_LAST;

	// Load sequencing. Power-down drops back to the load state so that the
	// straps are sampled again when the device resumes.
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			state <= scr_pkg::SCR_ST_LOAD;
		else if (!power_down_n_in)
			state <= scr_pkg::SCR_ST_LOAD;
		else
		begin
			case (state)
				scr_pkg::SCR_ST_LOAD: state <= scr_pkg::SCR_ST_RUN;
				scr_pkg::SCR_ST_RUN:  state <= scr_pkg::SCR_ST_RUN;
				default:              state <= scr_pkg::SCR_ST_LOAD;
			endcase
		end
	end

	// Register storage. Reset loads constants only; the strap-dependent
	// bits are merged in by the clocked load state after release.
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			bank[0] <= scr_pkg::RST_OWN;
			bank[1] <= scr_pkg::RST_PARTNER;
			bank[2] <= scr_pkg::RST_SPREAD_BASE;
			bank[3] <= scr_pkg::RST_CALIB;
			bank[4] <= scr_pkg::RST_LINK_BASE;
		end
		else if (state == scr_pkg::SCR_ST_LOAD)
		begin
			bank[0] <= scr_pkg::RST_OWN;
			bank[1] <= scr_pkg::RST_PARTNER;
			bank[2] <= scr_pkg::RST_SPREAD_BASE;
			bank[2][scr_pkg::BIT_SPREAD_LSB] <= strap_spread;
			bank[3] <= scr_pkg::RST_CALIB;
			bank[4] <= scr_pkg::RST_LINK_BASE;
			bank[4][scr_pkg::BIT_LINK_EN] <= strap_link;
			bank[4][scr_pkg::BIT_SLEEP]   <= strap_sleep;
		end
		else if (take && access_in.write && !locked && in_window)
		begin
			case (access_in.addr)
				scr_pkg::ADDR_OWN:     bank[0] <= access_in.wdata;
				scr_pkg::ADDR_PARTNER: bank[1] <= access_in.wdata;
				scr_pkg::ADDR_SPREAD:  bank[2] <= access_in.wdata;
				scr_pkg::ADDR_CALIB:   bank[3] <= access_in.wdata;
				scr_pkg::ADDR_LINK:    bank[4] <= access_in.wdata;
				default:               bank[0] <= bank[0];
			endcase
		end
	end

	// Read mux. The reserved low bit of the partner address reads as zero;
	// offsets above 0x04 belong to other blocks and read as zero here.
	always_comb
	begin
		next_rd_data = scr_pkg::RST_ZERO;
		case (access_in.addr)
			scr_pkg::ADDR_OWN:     next_rd_data = bank[0];
			scr_pkg::ADDR_PARTNER: next_rd_data = {bank[1][7:1], 1'b0};
			scr_pkg::ADDR_SPREAD:  next_rd_data = bank[2];
			scr_pkg::ADDR_CALIB:   next_rd_data = bank[3];
			scr_pkg::ADDR_LINK:    next_rd_data = bank[4];
			default:               next_rd_data = scr_pkg::RST_ZERO;
		endcase
	end

	// Answer path: one pulse for every taken access, data held until the
	// next read so a slow UART front end may pick it up late.
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			done_out    <= 1'b0;
			rd_data_out <= scr_pkg::RST_ZERO;
		end
		else
		begin
			done_out <= take;
			if (take && !access_in.write)
				rd_data_out <= next_rd_data;
		end
	end

	// Ready flag, registered so accesses wait for a loaded bank.
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			ready_out <= 1'b0;
		else
			ready_out <= power_down_n_in
				&& state == scr_pkg::SCR_ST_RUN;
	end

	// Field outputs, one cycle behind the bank. The lag is harmless since
	// the consumers are slow link controls, and it keeps outputs on flops.
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			config_out <= '0;
		else
		begin
			config_out.own_address_field           <= bank[0][7:1];
			config_out.partner_address_field       <= bank[1][7:1];
			config_out.spread_setting              <= bank[2][7:5];
			config_out.audio_channel_enable        <= bank[2][scr_pkg::BIT_AUDIO];
			config_out.pixel_clock_range           <= bank[2][3:2];
			config_out.serial_rate_range           <= bank[2][1:0];
			config_out.modulation_rate_calibration <= bank[3][7:6];
			config_out.sawtooth_divider            <= bank[3][5:0];
			config_out.serial_link_enable <= bank[4][scr_pkg::BIT_LINK_EN];
			config_out.configuration_link_enable
				<= bank[4][scr_pkg::BIT_CFG_LINK];
			config_out.pattern_test_enable <= bank[4][scr_pkg::BIT_PATTERN];
			config_out.sleep               <= bank[4][scr_pkg::BIT_SLEEP];
			config_out.control_interface_type <= bank[4][3:2];
			config_out.reverse_channel_enable <= bank[4][scr_pkg::BIT_REVERSE];
			config_out.forward_channel_enable <= bank[4][scr_pkg::BIT_FORWARD];
		end
	end

	// The local channel runs UART, and so full duplex, only for the pin
	// combination below; any other case is I2C and half duplex.
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			full_duplex_out <= 1'b0;
		else
			full_duplex_out <= bank[4][3:2] == scr_pkg::INTF_UART
				&& !control_interface_select_in
				&& control_direction_pin_in
				&& !role_select_pin_in;
	end

	// Checks on the bank's behaviour.
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence seq_load;
		state == scr_pkg::SCR_ST_LOAD && power_down_n_in;
	endsequence

	sequence seq_open_write;
		take && access_in.write && !locked && in_window;
	endsequence

	chk_bypass_refused: assert property (
		access_in.valid && !base_mode_in |=> !done_out)
		else $error("Bypass access was taken by the bank.");

	chk_pd_not_ready: assert property (
		!power_down_n_in |=> !ready_out ##1 !ready_out || power_down_n_in)
		else $error("Bank reported ready during power-down.");

	chk_address_defaults: assert property (
		seq_load |=> bank[0] == scr_pkg::RST_OWN
			&& bank[1] == scr_pkg::RST_PARTNER)
		else $error("Address registers missed their defaults.");

	chk_spread_strap: assert property (
		seq_load |=> bank[2][scr_pkg::BIT_SPREAD_LSB] == $past(strap_spread)
			&& bank[2][3:0] == scr_pkg::RST_SPREAD_BASE[3:0])
		else $error("Spread default does not follow the straps.");

	chk_link_defaults: assert property (
		seq_load |=> bank[4][scr_pkg::BIT_LINK_EN] == $past(strap_link)
			&& bank[4][scr_pkg::BIT_SLEEP] == $past(strap_sleep)
			&& bank[4][3:0] == scr_pkg::RST_LINK_BASE[3:0]
			&& bank[4][6:5] == 2'h0)
		else $error("Link enable register missed its defaults.");

	chk_write_stores: assert property (
		seq_open_write ##0 access_in.addr == scr_pkg::ADDR_CALIB
			|=> bank[3] == $past(access_in.wdata))
		else $error("Open write to calibration was not stored.");

	chk_lock_blocks: assert property (
		take && access_in.write && locked && state == scr_pkg::SCR_ST_RUN
			&& power_down_n_in
			|=> $stable(bank[0]) && $stable(bank[2]) && $stable(bank[4]))
		else $error("Write changed a locked register.");

	chk_read_answer: assert property (
		take && !access_in.write && access_in.addr == scr_pkg::ADDR_OWN
			|=> done_out && rd_data_out == $past(bank[0]))
		else $error("Read of own address returned wrong data.");

	chk_ready_after_load: assert property (
		seq_load ##1 power_down_n_in |=> ready_out)
		else $error("Bank not ready one cycle after loading.");

	chk_duplex_follows: assert property (
		full_duplex_out |-> $past(bank[4][3:2]) == scr_pkg::INTF_UART
			&& !$past(role_select_pin_in))
		else $error("Full duplex shown outside the UART case.");

endmodule // scr_config_regs

`default_nettype wire

// file: hdl/scr_pkg.sv
// Shared constants and types for the serializer configuration register bank.
// Assumes a control-channel front end that turns I2C or UART frames into
// single byte accesses, and strap pins already resolved to three levels.
`default_nettype none

package scr_pkg;

	// Register offsets within the configuration window.
	localparam logic [7:0] ADDR_OWN       = 8'h00;
	localparam logic [7:0] ADDR_PARTNER   = 8'h01;
	localparam logic [7:0] ADDR_SPREAD    = 8'h02;
	localparam logic [7:0] ADDR_CALIB     = 8'h03;
	localparam logic [7:0] ADDR_LINK      = 8'h04;
	localparam logic [7:0] ADDR_LOCK_LAST = 8'h1F;
	localparam int unsigned REG_COUNT     = 5;

	// Power-up values before strap-dependent bits are merged in.
	localparam logic [7:0] RST_OWN         = 8'h80;
	localparam logic [7:0] RST_PARTNER     = 8'h90;
	localparam logic [7:0] RST_SPREAD_BASE = 8'h1F;
	localparam logic [7:0] RST_CALIB       = 8'h00;
	localparam logic [7:0] RST_LINK_BASE   = 8'h07;
	localparam logic [7:0] RST_ZERO        = 8'h00;

	// Field positions.
	localparam int unsigned BIT_LOCK       = 0;
	localparam int unsigned BIT_RESERVED   = 0;
	localparam int unsigned BIT_SPREAD_LSB = 5;
	localparam int unsigned BIT_AUDIO      = 4;
	localparam int unsigned BIT_LINK_EN    = 7;
	localparam int unsigned BIT_CFG_LINK   = 6;
	localparam int unsigned BIT_PATTERN    = 5;
	localparam int unsigned BIT_SLEEP      = 4;
	localparam int unsigned BIT_REVERSE    = 1;
	localparam int unsigned BIT_FORWARD    = 0;

	// Control interface type value that selects the UART channel.
	localparam logic [1:0] INTF_UART = 2'h1;

	// Three-level strap encoding, two bits per pin.
	localparam logic [1:0] LVL_LOW  = 2'h0;
	localparam logic [1:0] LVL_HIGH = 2'h1;
	localparam logic [1:0] LVL_OPEN = 2'h2;

	// Bank load sequencing.
	typedef enum logic [0:0] {SCR_ST_LOAD, SCR_ST_RUN} scr_state_t;

	// One byte access from the control channel.
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} scr_access_t;

	// Decoded configuration handed to the rest of the serializer.
	typedef struct packed {
		logic [6:0] own_address_field;
		logic [6:0] partner_address_field;
		logic [2:0] spread_setting;
		logic       audio_channel_enable;
		logic [1:0] pixel_clock_range;
		logic [1:0] serial_rate_range;
		logic [1:0] modulation_rate_calibration;
		logic [5:0] sawtooth_divider;
		logic       serial_link_enable;
		logic       configuration_link_enable;
		logic       pattern_test_enable;
		logic       sleep;
		logic [1:0] control_interface_type;
		logic       reverse_channel_enable;
		logic       forward_channel_enable;
	} scr_config_t;

endpackage

`default_nettype wire

// file: verification/scr_mcu_model.sv
// Behavioural microcontroller on the control channel of the register bank.
// Assumes the bank answers a taken access with done_in one cycle later.
`timescale 1ns/1ps
`default_nettype none

module scr_mcu_model (
	input  wire logic                 clk_sys_in,  // Bank clock.
	input  wire logic                 done_in,     // Access taken pulse.
	input  wire logic [7:0]           rd_data_in,  // Read data.
	output var  scr_pkg::scr_access_t access_out   // One-cycle request.
);
	// Idle at time zero so the bank never sees an unknown request.
	initial
	begin
		access_out = '0;
	end

	// One byte access; address and data are inverted on release so that a
	// stale value can never pass for a held one. Only one device is modelled,
	// so a changed address must also go to the paired part by the caller.
	task automatic bus_cycle(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic took, output logic [7:0] rd);
		@(posedge clk_sys_in);
		access_out <= '{valid: 1'b1, write: w, addr: a, wdata: d};
		@(posedge clk_sys_in);
		access_out.valid <= 1'b0;
		access_out.addr  <= ~a;
		access_out.wdata <= ~d;
		#1;
		took = done_in;
		rd   = rd_data_in;
	endtask
endmodule // scr_mcu_model

`default_nettype wire

// file: verification/serializer_config_registers_tb_top.sv
// Self-checking bench for the serializer configuration register bank.
// Assumes the bank and its package are compiled first; one 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) \
	begin \
		checks_done++; \
		if ((got) !== (exp)) \
		begin \
			mismatches++; \
			$display("mismatch %s expected %0h seen %0h", what, exp, got); \
		end \
	end

module serializer_config_registers_tb_top;
	logic                 clk_sys;
	logic                 rst_n;
	logic                 power_down_n;
	logic [7:0]           straps;
	logic                 ctl_dir;
	logic                 role_pin;
	logic                 intf_sel;
	logic                 base_mode;
	scr_pkg::scr_access_t access;
	logic                 ready;
	logic                 done;
	logic [7:0]           rd_data;
	scr_pkg::scr_config_t cfg;
	logic                 full_duplex;
	int                   mismatches;
	int                   checks_done;
	logic [7:0]           tab_strap [4] = '{8'h00, 8'h12, 8'h44, 8'h00};
	logic                 tab_dir   [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
	logic [7:0]           tab_reg2  [4] = '{8'h1F, 8'h3F, 8'h3F, 8'h1F};
	logic [7:0]           tab_reg4  [4] = '{8'h17, 8'h87, 8'h07, 8'h07};

	scr_config_regs #(.STRAP_PINS(4)) uut (
		.clk_sys_in(clk_sys), .rst_n_in(rst_n),
		.power_down_n_in(power_down_n), .strap_inputs_in(straps),
		.control_direction_pin_in(ctl_dir), .role_select_pin_in(role_pin),
		.control_interface_select_in(intf_sel), .base_mode_in(base_mode),
		.access_in(access), .ready_out(ready), .done_out(done),
		.rd_data_out(rd_data), .config_out(cfg),
		.full_duplex_out(full_duplex)
	);

	scr_mcu_model mcu (
		.clk_sys_in(clk_sys), .done_in(done), .rd_data_in(rd_data),
		.access_out(access)
	);

	// Free-running 200 MHz clock.
	initial
	begin
		clk_sys = 1'b0;
	end
	always #2.5 clk_sys = ~clk_sys;

	// Prints the counts and the verdict; every path of the run ends here.
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic exp_done);
		logic       t;
		logic [7:0] r;
		mcu.bus_cycle(1'b1, a, d, t, r);
		`CHK("write done", exp_done, t)
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic       t;
		logic [7:0] r;
		mcu.bus_cycle(1'b0, a, 8'h00, t, r);
		`CHK("read done", 1'b1, t)
		`CHK("read data", exp, r)
	endtask

	// Bounded wait for the bank to finish loading its defaults.
	task automatic wait_ready();
		for (int n = 0; n < 6 && ready !== 1'b1; n++)
			@(posedge clk_sys);
		#1 `CHK("ready after load", 1'b1, ready)
	endtask

	// Power-down with new pin levels, then resume and reload the bank.
	task automatic reload(input logic [7:0] st, input logic dir);
		@(posedge clk_sys);
		power_down_n <= 1'b0;
		straps       <= st;
		ctl_dir      <= dir;
		wr(8'h03, 8'h11, 1'b0);
		#1 `CHK("ready while down", 1'b0, ready)
		@(posedge clk_sys);
		power_down_n <= 1'b1;
		wait_ready();
	endtask

	// Watchdog: the whole run needs well under a thousand cycles.
	initial
	begin
		#20000;
		mismatches++;
		test_done();
	end

	initial
	begin
		rst_n        <= 1'b0;
		power_down_n <= 1'b1;
		straps       <= 8'h00;
		ctl_dir      <= 1'b1;
		role_pin     <= 1'b0;
		intf_sel     <= 1'b0;
		base_mode    <= 1'b1;
		repeat (8) @(posedge clk_sys);
		#1 `CHK("ready in reset", 1'b0, ready)
		rst_n <= 1'b1;
		wait_ready();
		rd(8'h00, 8'h80);
		rd(8'h01, 8'h90);
		rd(8'h02, 8'h1F);
		rd(8'h03, 8'h00);
		rd(8'h04, 8'h17);
		`CHK("pixel range", 2'h3, cfg.pixel_clock_range)
		`CHK("rate range", 2'h3, cfg.serial_rate_range)
		`CHK("interface type", 2'h1, cfg.control_interface_type)
		`CHK("duplex", 1'b1, full_duplex)
		`CHK("own field", 7'h40, cfg.own_address_field)
		`CHK("partner field", 7'h48, cfg.partner_address_field)
		`CHK("spread field", 3'h0, cfg.spread_setting)
		`CHK("audio", 1'b1, cfg.audio_channel_enable)
		`CHK("mod cal init", 2'h0, cfg.modulation_rate_calibration)
		`CHK("divider init", 6'h00, cfg.sawtooth_divider)
		`CHK("link enable", 1'b0, cfg.serial_link_enable)
		`CHK("pattern", 1'b0, cfg.pattern_test_enable)
		`CHK("sleep init", 1'b1, cfg.sleep)
		`CHK("reverse", 1'b1, cfg.reverse_channel_enable)
		`CHK("forward", 1'b1, cfg.forward_channel_enable)
		// Strap and direction combinations, each loaded by a power-down exit.
		for (int i = 0; i < 4; i++)
		begin
			reload(tab_strap[i], tab_dir[i]);
			rd(8'h02, tab_reg2[i]);
			rd(8'h04, tab_reg4[i]);
		end
		`CHK("sleep field", 1'b0, cfg.sleep)
		// Writes and readback, including the reserved bit and unmapped offset 0x05.
		wr(8'h03, 8'hAA, 1'b1);
		@(posedge clk_sys);
		#1 `CHK("divider", 6'h2A, cfg.sawtooth_divider)
		`CHK("mod cal", 2'h2, cfg.modulation_rate_calibration)
		rd(8'h03, 8'hAA);
		wr(8'h01, 8'h91, 1'b1);
		rd(8'h01, 8'h90);
		wr(8'h04, 8'h47, 1'b1);
		rd(8'h04, 8'h47);
		`CHK("cfg link", 1'b1, cfg.configuration_link_enable)
		wr(8'h05, 8'hAA, 1'b1);
		rd(8'h05, 8'h00);
		// Bypass mode drops register traffic without an answer.
		@(posedge clk_sys);
		base_mode <= 1'b0;
		wr(8'h03, 8'h55, 1'b0);
		@(posedge clk_sys);
		base_mode <= 1'b1;
		rd(8'h03, 8'hAA);
		// Duplex with UART type and direction high, then dropped by the role and select pins.
		ctl_dir <= 1'b1;
		wr(8'h04, 8'h17, 1'b1);
		@(posedge clk_sys);
		#1 `CHK("duplex on", 1'b1, full_duplex)
		role_pin <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 `CHK("duplex role", 1'b0, full_duplex)
		role_pin <= 1'b0;
		intf_sel <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 `CHK("duplex select", 1'b0, full_duplex)
		intf_sel <= 1'b0;
		// Lock: later writes are answered but change nothing.
		wr(8'h00, 8'h81, 1'b1);
		wr(8'h02, 8'h00, 1'b1);
		rd(8'h02, 8'h1F);
		wr(8'h00, 8'h80, 1'b1);
		rd(8'h00, 8'h81);
		reload(8'h00, 1'b1);
		rd(8'h00, 8'h80);
		test_done();
	end
endmodule // serializer_config_registers_tb_top

`default_nettype wire
